// File: pkg/fperr_defines.svh
// Constants for the floating-point error pin reporting block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef FPERR_DEFINES_SVH
`define FPERR_DEFINES_SVH

// ----------------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------------
`define FPERR_NE_BIT 5
`define FPERR_NUM_EXC 6
`define FPERR_IP_W 32
`define FPERR_VEC_W 8

// ----------------------------------------------------------------------------
// Values and reset values
// ----------------------------------------------------------------------------
`define FPERR_MF_VECTOR 8'h10
`define FPERR_FLAGS_RST 6'h00
`define FPERR_IP_RST 32'h0000_0000
`define FPERR_VEC_RST 8'h00
`define FPERR_PIN_IDLE 1'b1

`endif

// File: pkg/fperr_pkg.sv
// Types shared by the floating-point error pin reporting block.
// Assumes the defines header is on the include path.
`include "fperr_defines.svh"

package fperr_pkg;

  // ----------------------------------------------------------------------------
  // Instruction classes seen at issue
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    FPERR_K_OTHER = 3'h0,
    FPERR_K_FP_WAITING = 3'h1,
    FPERR_K_WAIT = 3'h2,
    FPERR_K_SIMD = 3'h3,
    FPERR_K_CLEAR = 3'h4,
    FPERR_K_INIT = 3'h5,
    FPERR_K_STORE_NOWAIT = 3'h6
  } fperr_kind_e;

  // ----------------------------------------------------------------------------
  // Reporting states, one-hot
  // ----------------------------------------------------------------------------
  typedef enum logic [3:0] {
    FPERR_S_IDLE = 4'h1,
    FPERR_S_PEND = 4'h2,
    FPERR_S_FROZEN = 4'h4,
    FPERR_S_RAISED = 4'h8
  } fperr_state_e;

  typedef logic [`FPERR_NUM_EXC-1:0] fperr_flags_t;

endpackage

// File: pkg/fperr_pin_if.sv
// Carrier between the pin synchroniser and the reporting core.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ns

interface fperr_pin_if;
  logic ignore_raw_n;
  logic maskable_interrupt_req_in_raw;
  logic ignore_sync_n;
  logic maskable_interrupt_req_in_sync;

  // Synchroniser end
  modport sync_side (
    input ignore_raw_n,
    input maskable_interrupt_req_in_raw,
    output ignore_sync_n,
    output maskable_interrupt_req_in_sync
  );

  // Core end
  modport core_side (
    output ignore_raw_n,
    output maskable_interrupt_req_in_raw,
    input ignore_sync_n,
    input maskable_interrupt_req_in_sync
  );
endinterface

// File: hdl/fperr_sync2.sv
// Two-flop synchroniser for the asynchronous input pins.
// Assumes pins change freely relative to clk; reset holds idle levels.
`timescale 1ns/1ns
`include "fperr_defines.svh"

module fperr_sync2 (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Pin carrier
  fperr_pin_if.sync_side pins
);
  import fperr_pkg::*;

  // ----------------------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------------------
  localparam logic [1:0] IDLE_LVL = {`FPERR_PIN_IDLE, 1'b0};
  logic [1:0] raw_in;
  logic [1:0] stage1_reg;
  logic [1:0] stage2_reg;

  assign raw_in = {pins.ignore_raw_n, pins.maskable_interrupt_req_in_raw};

  // Each pin gets two flops; first flop feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_bit
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          stage1_reg[gi] <= IDLE_LVL[gi];
          stage2_reg[gi] <= IDLE_LVL[gi];
        end else begin
          stage1_reg[gi] <= raw_in[gi];
          stage2_reg[gi] <= stage1_reg[gi];
        end
      end
    end
  endgenerate

  assign pins.ignore_sync_n = stage2_reg[1];
  assign pins.maskable_interrupt_req_in_sync = stage2_reg[0];
endmodule

// File: hdl/fperr_top.sv
// Floating-point error reporting: flags, stall, native exception and error pin.
// Assumes the arithmetic unit reports exceptions and the issue stage offers
// one instruction at a time; pins come from outside the clock domain.
`timescale 1ns/1ns
`include "fperr_defines.svh"

module fperr_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic [31:0] ctrl_word0,
  input wire logic defer_error_pin,
  // Exception report from arithmetic
  input wire logic exc_valid,
  input wire fperr_pkg::fperr_flags_t exc_flags,
  input wire fperr_pkg::fperr_flags_t exc_mask,
  input wire logic [`FPERR_IP_W-1:0] exc_ip,
  // Instruction issue
  input wire logic instr_valid,
  input wire fperr_pkg::fperr_kind_e instr_kind,
  output logic instr_ready,
  // Pins
  input wire logic ignore_numeric_error_in_n,
  input wire logic maskable_interrupt_req_in,
  output logic fp_error_out_n,
  // Status and exception delivery
  output fperr_pkg::fperr_flags_t fp_status_flags,
  output logic error_summary_flag,
  output logic [`FPERR_IP_W-1:0] fault_ip,
  output logic fp_error_exception_req,
  output logic [`FPERR_VEC_W-1:0] fp_error_exception_vector,
  output logic ext_interrupt_req,
  output logic single_logical_proc
);
  import fperr_pkg::*;

  // ----------------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------------
  fperr_pin_if pins ();

  assign pins.ignore_raw_n = ignore_numeric_error_in_n;
  assign pins.maskable_interrupt_req_in_raw = maskable_interrupt_req_in;

  fperr_sync2 u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pins(pins.sync_side)
  );

  // ----------------------------------------------------------------------------
  // Instruction class decode
  // ----------------------------------------------------------------------------
  // Instructions that check for pending errors
  function automatic logic is_waiting(input fperr_kind_e k);
    return (k == FPERR_K_FP_WAITING) || (k == FPERR_K_WAIT) || (k == FPERR_K_SIMD);
  endfunction

  // Instructions that discard pending errors
  function automatic logic is_clearing(input fperr_kind_e k);
    return (k == FPERR_K_CLEAR) || (k == FPERR_K_INIT);
  endfunction

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  fperr_flags_t flags_reg;
  fperr_flags_t flags_next;
  logic es_reg;
  logic es_next;
  logic pin_reg;
  logic pin_next;
  logic raise_reg;
  logic [`FPERR_VEC_W-1:0] vec_reg;
  logic [`FPERR_IP_W-1:0] ip_reg;
  fperr_state_e state_reg;
  fperr_state_e state_next;

  // ----------------------------------------------------------------------------
  // Decode and selection
  // ----------------------------------------------------------------------------
  wire native_mode = ctrl_word0[`FPERR_NE_BIT];
  wire ignore_active = !native_mode && !pins.ignore_sync_n;
  wire fperr_flags_t unmasked = exc_flags & ~exc_mask;
  wire new_exc = exc_valid && (|unmasked) && !ignore_active;
  wire waiting_req = instr_valid && is_waiting(instr_kind);
  wire blocked = es_reg && waiting_req && !ignore_active;
  wire accepted = instr_valid && !blocked;
  wire do_clear = accepted && is_clearing(instr_kind);
  wire pin_set = es_reg && !native_mode && !ignore_active &&
                 (!defer_error_pin || waiting_req);
  wire raise_fire = (state_reg == FPERR_S_PEND) && native_mode && blocked;

  // Clear first, new exception on top so a same-cycle set wins
  assign flags_next = (do_clear ? `FPERR_FLAGS_RST : flags_reg) |
                      (new_exc ? unmasked : `FPERR_FLAGS_RST);
  assign es_next = |flags_next;
  // Pin holds until the flags are cleared
  assign pin_next = (pin_reg || pin_set) && es_next;

  // ----------------------------------------------------------------------------
  // Reporting state machine
  // ----------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FPERR_S_IDLE: begin
        if (es_next) begin
          state_next = FPERR_S_PEND;
        end
      end
      FPERR_S_PEND: begin
        if (!es_next) begin
          state_next = FPERR_S_IDLE;
        end else if (raise_fire) begin
          state_next = FPERR_S_RAISED;
        end else if (blocked) begin
          state_next = FPERR_S_FROZEN;
        end
      end
      FPERR_S_FROZEN, FPERR_S_RAISED: begin
        if (!es_next) begin
          state_next = FPERR_S_IDLE;
        end
      end
      default: begin
        state_next = FPERR_S_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  // Flags, pin and state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_reg <= `FPERR_FLAGS_RST;
      es_reg <= 1'b0;
      pin_reg <= 1'b0;
      state_reg <= FPERR_S_IDLE;
    end else begin
      flags_reg <= flags_next;
      es_reg <= es_next;
      pin_reg <= pin_next;
      state_reg <= state_next;
    end
  end

  // Exception delivery and faulting pointer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      raise_reg <= 1'b0;
      vec_reg <= `FPERR_VEC_RST;
      ip_reg <= `FPERR_IP_RST;
    end else begin
      raise_reg <= raise_fire;
      if (raise_fire) begin
        vec_reg <= `FPERR_MF_VECTOR;
      end
      if (new_exc) begin
        ip_reg <= exc_ip;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign instr_ready = !blocked;
  assign fp_error_out_n = !pin_reg;
  assign fp_status_flags = flags_reg;
  assign error_summary_flag = es_reg;
  assign fault_ip = ip_reg;
  assign fp_error_exception_req = raise_reg;
  assign fp_error_exception_vector = vec_reg;
  assign ext_interrupt_req = pins.maskable_interrupt_req_in_sync;
  assign single_logical_proc = !native_mode;

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_stall_on_pending: assert property (
    es_reg && waiting_req && !ignore_active |-> !instr_ready)
    else $error("waiting instruction taken while error pending");

  a_nowait_passes: assert property (
    instr_valid && !is_waiting(instr_kind) |-> instr_ready)
    else $error("non-waiting instruction stalled");

  a_flags_set: assert property (
    new_exc && !do_clear |=> ((fp_status_flags & $past(unmasked)) == $past(unmasked))
      && error_summary_flag)
    else $error("unmasked exception did not set flags");

  a_pin_hold: assert property (
    !fp_error_out_n && error_summary_flag |=> !fp_error_out_n || !error_summary_flag)
    else $error("error pin released with flags pending");

  a_pin_immediate: assert property (
    es_reg && !native_mode && !ignore_active && !defer_error_pin && !do_clear
      |=> !fp_error_out_n)
    else $error("error pin not asserted at once");

  a_ignore_drops: assert property (
    exc_valid && ignore_active && !do_clear |=> fp_status_flags == $past(fp_status_flags))
    else $error("exception recorded while ignore input asserted");

  a_native_raise: assert property (
    state_reg == FPERR_S_PEND && native_mode && blocked
      |=> fp_error_exception_req && fp_error_exception_vector == 8'h10 ##1
        !fp_error_exception_req)
    else $error("native exception not raised as one pulse of vector 16");

  a_compat_no_raise: assert property (
    fp_error_exception_req |-> $past(native_mode))
    else $error("internal exception raised in pin mode");

  a_fault_ptr: assert property (
    new_exc |=> fault_ip == $past(exc_ip))
    else $error("faulting pointer not captured");

  a_single_proc: assert property (
    !fp_error_out_n && !native_mode |-> single_logical_proc)
    else $error("pin reporting with several processors allowed");

  c_pin_report: cover property (new_exc && !native_mode ##[1:8] !fp_error_out_n);
  c_native_raise: cover property (fp_error_exception_req);
  c_frozen_clear: cover property (state_reg == FPERR_S_FROZEN ##[1:20] state_reg == FPERR_S_IDLE);
  c_set_and_clear: cover property (new_exc && do_clear);
endmodule

// File: tb/fperr_pic_model.sv
// Glue logic and cascaded interrupt controller beside the error pin.
// Assumes an active-low error pin and the same core clock as the block.
`timescale 1ns/1ns

module fperr_pic_model #(
  parameter int EXTRA = 0,
  parameter int IRQ_LINE = 13,
  parameter logic [7:0] VECTOR = 8'h75
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Pin from the block
  input wire logic fp_error_out_n,
  // Request back to the block and vector read by the bench
  output logic maskable_interrupt_req_in,
  output logic [7:0] int_vector
);
  logic [15:0] irq_lines;
  logic [EXTRA:0] dly_reg;
  logic [EXTRA+1:0] dly_shift;

  // Error pin wired to one controller input
  assign irq_lines = (16'h0001 << IRQ_LINE) & {16{~fp_error_out_n}};

  // Newest sample enters at the bottom; the top bit is the request
  assign dly_shift = {dly_reg, irq_lines[IRQ_LINE]};

  // Controller answers after EXTRA+1 edges; slower when EXTRA grows
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dly_reg <= '0;
    end else begin
      dly_reg <= dly_shift[EXTRA:0];
    end
  end

  // Request shown to the block; vector to the bench while it is high
  assign maskable_interrupt_req_in = dly_reg[EXTRA];
  assign int_vector = maskable_interrupt_req_in ? VECTOR : 8'h00;
endmodule

// File: tb/testbench.sv
// Self-checking bench for the error reporting block.
// Assumes the package is compiled first and the controller model beside it.
`timescale 1ns/1ns

module testbench;
  import fperr_pkg::*;

  // ---------------------------------------------------------------
  // Stimulus, observation and expectation
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [31:0] ctrl_word0 = 32'h0000_0000;
  logic defer_error_pin = 1'b0;
  logic exc_valid = 1'b0;
  fperr_flags_t exc_flags = 6'h00;
  fperr_flags_t exc_mask = 6'h00;
  logic [31:0] exc_ip = 32'h0000_0000;
  logic instr_valid = 1'b0;
  fperr_kind_e instr_kind = FPERR_K_OTHER;
  logic ignore_numeric_error_in_n = 1'b1;
  logic instr_ready, maskable_interrupt_req_in, fp_error_out_n;
  logic error_summary_flag, fp_error_exception_req;
  logic ext_interrupt_req, single_logical_proc;
  fperr_flags_t fp_status_flags;
  logic [31:0] fault_ip;
  logic [7:0] fp_error_exception_vector, int_vector;
  fperr_flags_t e_flags = 6'h00;
  logic e_pin = 1'b1;
  logic e_ready = 1'b1;
  logic e_req = 1'b0;
  logic e_maskable_interrupt_req_in = 1'b0;
  logic [7:0] e_vec = 8'h00;
  logic [31:0] e_ip = 32'h0000_0000;
  logic [51:0] exp_q[$];
  int fail_count = 0;
  int checks = 0;
  wire [51:0] obs = {fault_ip, fp_error_exception_vector, fp_status_flags,
    error_summary_flag, fp_error_out_n, instr_ready, fp_error_exception_req,
    ext_interrupt_req, single_logical_proc};

  fperr_top u_dut (.clk(clk), .rst_b(rst_b), .ctrl_word0(ctrl_word0),
    .defer_error_pin(defer_error_pin), .exc_valid(exc_valid), .exc_flags(exc_flags),
    .exc_mask(exc_mask), .exc_ip(exc_ip), .instr_valid(instr_valid),
    .instr_kind(instr_kind), .instr_ready(instr_ready),
    .ignore_numeric_error_in_n(ignore_numeric_error_in_n),
    .maskable_interrupt_req_in(maskable_interrupt_req_in),
    .fp_error_out_n(fp_error_out_n), .fp_status_flags(fp_status_flags),
    .error_summary_flag(error_summary_flag), .fault_ip(fault_ip),
    .fp_error_exception_req(fp_error_exception_req),
    .fp_error_exception_vector(fp_error_exception_vector),
    .ext_interrupt_req(ext_interrupt_req), .single_logical_proc(single_logical_proc));

  fperr_pic_model u_pic (.clk(clk), .rst_b(rst_b), .fp_error_out_n(fp_error_out_n),
    .maskable_interrupt_req_in(maskable_interrupt_req_in), .int_vector(int_vector));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [51:0] seen, input logic [51:0] want);
    checks++;
    if (seen !== want) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic note();
    exp_q.push_back({e_ip, e_vec, e_flags, |e_flags, e_pin, e_ready, e_req, e_maskable_interrupt_req_in,
      ~ctrl_word0[5]});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One-cycle exception report; take says whether it should be recorded
  // Leading edge keeps strobes and notes of back-to-back calls apart
  task automatic report(input fperr_flags_t f, input fperr_flags_t m, input logic take);
    tick(1);
    exc_flags = f;
    exc_mask = m;
    exc_ip = $urandom;
    exc_valid = 1'b1;
    tick(1);
    exc_valid = 1'b0;
    if (take) begin
      e_flags = e_flags | (f & ~m);
      e_ip = exc_ip;
    end
    note();
  endtask

  // Offer one instruction for one cycle, ready level expected
  task automatic offer(input fperr_kind_e k, input logic rdy);
    tick(1);
    instr_kind = k;
    instr_valid = 1'b1;
    e_ready = rdy;
    note();
    tick(1);
    instr_valid = 1'b0;
    e_ready = 1'b1;
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Clock, watchdog and result watcher
  // ---------------------------------------------------------------
  initial forever #50 clk = ~clk;

  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    conclude();
  end

  always @(negedge clk) begin
    if (exp_q.size() > 0) check(obs, exp_q.pop_front());
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(54));
    repeat (20) @(posedge clk);
    #1;
    rst_b = 1'b1;
    note();
    tick(2);
    // Pin mode, error pin at once, stall and controller loop
    report(6'($urandom_range(1, 63)), 6'h00, 1'b1);
    tick(1);
    e_pin = 1'b0;
    note();
    tick(4);
    e_maskable_interrupt_req_in = 1'b1;
    note();
    check(52'(int_vector), 52'h75);
    for (int k = 1; k <= 3; k++) offer(fperr_kind_e'(k), 1'b0);
    offer(FPERR_K_OTHER, 1'b1);
    offer(FPERR_K_STORE_NOWAIT, 1'b1);
    report(6'h20, 6'h00, 1'b1);
    offer(FPERR_K_CLEAR, 1'b1);
    e_flags = 6'h00;
    e_pin = 1'b1;
    note();
    tick(4);
    e_maskable_interrupt_req_in = 1'b0;
    report(6'h15, 6'h15, 1'b0);
    // Deferred pin, raised only at the next waiting instruction
    defer_error_pin = 1'b1;
    report(6'($urandom_range(1, 63)), 6'h00, 1'b1);
    tick(2);
    note();
    offer(FPERR_K_FP_WAITING, 1'b0);
    e_pin = 1'b0;
    note();
    // Ignore input: no stall, no new records, pin held
    ignore_numeric_error_in_n = 1'b0;
    tick(3);
    e_maskable_interrupt_req_in = 1'b1;
    offer(FPERR_K_SIMD, 1'b1);
    report(6'h01, 6'h00, 1'b0);
    ignore_numeric_error_in_n = 1'b1;
    offer(FPERR_K_INIT, 1'b1);
    e_flags = 6'h00;
    e_pin = 1'b1;
    note();
    tick(4);
    e_maskable_interrupt_req_in = 1'b0;
    // Native mode: internal exception, pin left idle
    defer_error_pin = 1'b0;
    ctrl_word0 = 32'h0000_0020;
    note();
    tick(1);
    report(6'($urandom_range(1, 63)), 6'h00, 1'b1);
    tick(2);
    note();
    offer(FPERR_K_WAIT, 1'b0);
    e_req = 1'b1;
    e_vec = 8'h10;
    note();
    tick(1);
    e_req = 1'b0;
    offer(FPERR_K_SIMD, 1'b0);
    note();
    offer(FPERR_K_CLEAR, 1'b1);
    e_flags = 6'h00;
    note();
    tick(3);
    conclude();
  end
endmodule
